/* File: core/cpdc_gate_bank.sv */
// Purpose: Glitch-free gating of the single-ended clock outputs.
// Assumes: Stop request is a level from the sequencer.
// Notes:   A gate closes or opens only while its source is low.
module cpdc_gate_bank
  import cpdc_pkg::*;
(
  input  wire logic sys_clk_i,
  input  wire logic rst_n_i,
  cpdc_gate_if.bank gate
);
  logic [SE_NUM-1:0] stop_r;
  logic [SE_NUM-1:0] out_r;

  // ==========================================================
  // Gate flags
  // ==========================================================
  always_ff @(posedge sys_clk_i)
  begin
    if (!rst_n_i)
      stop_r <= '1;
    else if (gate.stop_req)
      stop_r <= stop_r | ~gate.clk_in; // Close on low phase
    else
      stop_r <= stop_r & gate.clk_in; // Reopen on low phase
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (!rst_n_i)
      out_r <= '0;
    else
      out_r <= gate.clk_in & ~stop_r;
  end

  assign gate.clk_out     = out_r;
  assign gate.all_stopped = &stop_r;

  // ==========================================================
  // Checks
  // ==========================================================
  chk_stopped_low: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    (gate.stop_req && (&stop_r)) |=> (out_r == '0))
    else $error("gated output high after stop");
  chk_no_runt: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    !(|(out_r & ~$past(out_r) & $past(gate.clk_in, 2))))
    else $error("gated pulse started late");
  chk_no_cut: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    !(|($past(out_r) & ~out_r & $past(gate.clk_in))))
    else $error("gated pulse cut short");
endmodule // cpdc_gate_bank

/* File: core/cpdc_gate_if.sv */
// Purpose: Carrier between the sequencer and the output gate bank.
// Assumes: One clock domain.
// Notes:   Bank owns the gated outputs and the stopped flag.
interface cpdc_gate_if;
  import cpdc_pkg::*;
  logic              stop_req;
  logic [SE_NUM-1:0] clk_in;
  logic [SE_NUM-1:0] clk_out;
  logic              all_stopped;
  modport ctrl (output stop_req, output clk_in, input clk_out, input all_stopped);
  modport bank (input stop_req, input clk_in, output clk_out, output all_stopped);
endinterface

/* File: core/cpdc_pkg.sv */
// Purpose: Shared constants and types for the clock power-down control.
// Assumes: 250 MHz system clock; clock waveforms arrive as same-clock levels.
// Notes:   Long restart count is a top-level parameter.
package cpdc_pkg;
  // ==========================================================
  // Counts and timing
  // ==========================================================
  localparam int SE_NUM          = 17;
  localparam int CLK_PERIOD_NS   = 4;
  localparam int RESTART_TIME_NS = 1800000;
  localparam int RESTART_CYCLES  = RESTART_TIME_NS / CLK_PERIOD_NS;
  localparam int DRIVE_TIME_NS   = 300000;
  localparam int DRIVE_CYCLES    = DRIVE_TIME_NS / CLK_PERIOD_NS;
  localparam int WAKE_CNT_W      = 19;
  localparam logic [WAKE_CNT_W-1:0] WAKE_CNT_ZERO = 19'h00000;
  localparam logic [WAKE_CNT_W-1:0] WAKE_CNT_ONE  = 19'h00001;

  // ==========================================================
  // Sequencer states, Gray along the usual path
  // ==========================================================
  typedef enum logic [1:0] {
    ST_RUN  = 2'h0,
    ST_STOP = 2'h1,
    ST_DOWN = 2'h3,
    ST_WAKE = 2'h2
  } cpdc_state_type;
endpackage

/* File: core/cpdc_top.sv */
// Purpose: Power-down sequencer for the clock synthesizer outputs.
// Assumes: Clock waveforms are same-clock levels; power_down_n is a pin.
// Notes:   CPU outputs lag their sources by one cycle, single-ended outputs by two.
module cpdc_top
  import cpdc_pkg::*;
#(
  parameter int WAKE_CYCLES = RESTART_CYCLES - DRIVE_CYCLES
)
(
  input  wire logic              sys_clk_i,
  input  wire logic              rst_n_i,
  input  wire logic              power_down_n_i,
  input  wire logic              tristate_cfg_i,
  input  wire logic              cpu_clk_true_i,
  input  wire logic              cpu_clk_comp_i,
  input  wire logic [SE_NUM-1:0] se_clk_i,
  output logic      [SE_NUM-1:0] se_clk_o,
  output logic                   cpu_clk_true_out_o,
  output logic                   cpu_clk_true_oe_o,
  output logic                   cpu_iref_2x_o,
  output logic                   cpu_clk_comp_out_o,
  output logic                   cpu_clk_comp_oe_o,
  output logic                   pll_enable_o
);
  cpdc_gate_if gate ();

  logic                  pd_s1_r;
  logic                  pd_s2_r;
  logic                  comp_q_r;
  logic                  low_seen_r;
  logic                  comp_rise;
  logic                  enter_pd;
  cpdc_state_type        state_r;
  cpdc_state_type        state_nxt;
  logic [WAKE_CNT_W-1:0] wake_cnt_r;
  logic                  wake_done;
  logic                  cpu_stop_r;
  logic                  se_ready_r;

  // ==========================================================
  // Pin synchroniser and comp edge sampling
  // ==========================================================
  always_ff @(posedge sys_clk_i)
  begin
    if (!rst_n_i)
    begin
      pd_s1_r <= 1'b1;
      pd_s2_r <= 1'b1;
    end
    else
    begin
      pd_s1_r <= power_down_n_i;
      pd_s2_r <= pd_s1_r;
    end
  end

  assign comp_rise = cpu_clk_comp_i && !comp_q_r;
  assign enter_pd  = comp_rise && !pd_s2_r && low_seen_r;

  always_ff @(posedge sys_clk_i)
  begin
    if (!rst_n_i)
    begin
      comp_q_r   <= 1'b0;
      low_seen_r <= 1'b0;
    end
    else
    begin
      comp_q_r <= cpu_clk_comp_i;
      if (comp_rise)
        low_seen_r <= !pd_s2_r;
    end
  end

  // ==========================================================
  // Sequencer
  // ==========================================================
  assign wake_done = (wake_cnt_r == WAKE_CYCLES[WAKE_CNT_W-1:0]);

  always_comb
  begin
    state_nxt = state_r;
    case (state_r)
      ST_RUN:  if (enter_pd) state_nxt = ST_STOP;
      ST_STOP: if (gate.all_stopped && cpu_stop_r) state_nxt = ST_DOWN;
      ST_DOWN: if (pd_s2_r) state_nxt = ST_WAKE;
      ST_WAKE: if (wake_done) state_nxt = ST_RUN;
      default: state_nxt = ST_RUN;
    endcase
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (!rst_n_i)
      state_r <= ST_RUN;
    else
      state_r <= state_nxt;
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (!rst_n_i)
      wake_cnt_r <= WAKE_CNT_ZERO;
    else if (state_r == ST_WAKE)
      wake_cnt_r <= wake_cnt_r + WAKE_CNT_ONE;
    else
      wake_cnt_r <= WAKE_CNT_ZERO;
  end

  // ==========================================================
  // PLL enable and single-ended gating
  // ==========================================================
  always_ff @(posedge sys_clk_i)
  begin
    if (!rst_n_i)
      pll_enable_o <= 1'b1;
    else
      pll_enable_o <= (state_nxt != ST_DOWN);
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (!rst_n_i)
      se_ready_r <= 1'b0;
    else
      se_ready_r <= (state_nxt == ST_RUN);
  end

  assign gate.stop_req = !se_ready_r;
  assign gate.clk_in   = se_clk_i;

  always_ff @(posedge sys_clk_i)
  begin
    if (!rst_n_i)
      se_clk_o <= '0;
    else
      se_clk_o <= gate.clk_out;
  end

  cpdc_gate_bank u_bank (
    .sys_clk_i (sys_clk_i),
    .rst_n_i   (rst_n_i),
    .gate      (gate)
  );

  // ==========================================================
  // CPU differential pair
  // ==========================================================
  always_ff @(posedge sys_clk_i)
  begin
    if (!rst_n_i)
      cpu_stop_r <= 1'b0;
    else if (state_r == ST_RUN)
      cpu_stop_r <= 1'b0;
    else if (!cpu_clk_comp_i)
      cpu_stop_r <= 1'b1;
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (!rst_n_i)
    begin
      cpu_clk_true_out_o <= 1'b0;
      cpu_clk_true_oe_o  <= 1'b0;
      cpu_iref_2x_o      <= 1'b0;
      cpu_clk_comp_out_o <= 1'b0;
      cpu_clk_comp_oe_o  <= 1'b0;
    end
    else if (state_r == ST_WAKE)
    begin
      cpu_clk_true_out_o <= 1'b0;
      cpu_clk_true_oe_o  <= 1'b1;
      cpu_iref_2x_o      <= 1'b0;
      cpu_clk_comp_out_o <= 1'b1;
      cpu_clk_comp_oe_o  <= 1'b1;
    end
    else if (cpu_stop_r && state_r != ST_RUN)
    begin
      cpu_clk_true_out_o <= 1'b1;
      cpu_clk_true_oe_o  <= !tristate_cfg_i;
      cpu_iref_2x_o      <= !tristate_cfg_i;
      cpu_clk_comp_out_o <= 1'b0;
      cpu_clk_comp_oe_o  <= 1'b0;
    end
    else
    begin
      cpu_clk_true_out_o <= cpu_clk_true_i;
      cpu_clk_true_oe_o  <= 1'b1;
      cpu_iref_2x_o      <= 1'b0;
      cpu_clk_comp_out_o <= cpu_clk_comp_i;
      cpu_clk_comp_oe_o  <= 1'b1;
    end
  end

  // ==========================================================
  // Checks
  // ==========================================================
  chk_entry_two_low: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    (state_r == ST_RUN && comp_rise && !pd_s2_r && low_seen_r) |=> (state_r == ST_STOP))
    else $error("entry missed after two low samples");
  chk_no_early_entry: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    (state_r == ST_RUN && !(comp_rise && !pd_s2_r && low_seen_r)) |=> (state_r == ST_RUN))
    else $error("entry without two low samples");
  chk_cpu_park: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    (state_r == ST_DOWN && $past(state_r) == ST_DOWN && $past(!tristate_cfg_i))
    |-> (cpu_clk_true_out_o && cpu_clk_true_oe_o && cpu_iref_2x_o && !cpu_clk_comp_oe_o))
    else $error("cpu pair not parked");
  chk_cpu_tristate: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    (state_r == ST_DOWN && $past(state_r) == ST_DOWN && $past(tristate_cfg_i))
    |-> (!cpu_clk_true_oe_o && !cpu_clk_comp_oe_o))
    else $error("cpu pair driven in three-state mode");
  chk_sync_stop: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    (state_r == ST_STOP && gate.all_stopped && cpu_stop_r) |=> (state_r == ST_DOWN))
    else $error("down not reached once all stopped");
  chk_pll_off: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    (state_r == ST_DOWN) |-> !pll_enable_o)
    else $error("pll enabled while down");
  chk_restart_bound: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    (state_r == ST_WAKE) |-> (wake_cnt_r <= WAKE_CYCLES[WAKE_CNT_W-1:0]))
    else $error("restart not within bound");
  chk_restart_exit: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    (state_r == ST_WAKE && wake_done) |=> (state_r == ST_RUN))
    else $error("restart count ended without run");
  chk_cpu_drive: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    $rose(state_r == ST_WAKE) |=> (cpu_clk_true_oe_o && cpu_clk_comp_oe_o)[*2])
    else $error("cpu pair not driven after release");
endmodule // cpdc_top

/* File: tb/cpdc_board_model.sv */
// Purpose: Board side: source waveforms and the power-down pin.
// Assumes: Sources are same-clock levels.
// Notes:   Pin follows the bench request one cycle later.
module cpdc_board_model
  import cpdc_pkg::*;
(
  input  wire logic              sys_clk_i,
  input  wire logic              pd_req_i,
  input  wire logic [SE_NUM-1:0] phase_i,
  output logic                   power_down_n_o,
  output logic                   cpu_true_o,
  output logic                   cpu_comp_o,
  output logic [SE_NUM-1:0]      se_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [2:0] div_r = 3'h0;
  logic       pin_r = 1'h1;
  always_ff @(posedge sys_clk_i)
  begin
    div_r <= div_r + 3'h1;
    pin_r <= ~pd_req_i;
  end
  assign power_down_n_o = pin_r;
  assign cpu_true_o     = div_r[1];
  assign cpu_comp_o     = ~div_r[1];
  assign se_o           = {SE_NUM{div_r[2]}} ^ phase_i;
endmodule // cpdc_board_model

/* File: tb/testbench.sv */
// Purpose: Self-checking bench for the clock power-down control.
// Assumes: Board model supplies sources and the pin.
// Notes:   Restart count shortened through WAKE_CYCLES.
module testbench
  import cpdc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int WAKE = 20;
  logic              sys_clk_i = 1'h0;
  logic              rst_n_i = 1'h0;
  logic              pd_req = 1'h0;
  logic              cfg = 1'h0;
  logic              run_chk = 1'h0;
  logic [SE_NUM-1:0] phase = {SE_NUM{1'h0}};
  logic [SE_NUM-1:0] se_in, se_out, se_d1, se_d2;
  logic              pd_n, c_t, c_c, c_d1, t_out, t_oe, iref, c_out, c_oe, pll;
  int                bad_count = 0;
  int                n_compared = 0;
  int unsigned       seed = 45;
  int                hold;
  int                hi_len [SE_NUM] = '{default: 0};
  cpdc_board_model board (.sys_clk_i(sys_clk_i), .pd_req_i(pd_req), .phase_i(phase),
    .power_down_n_o(pd_n), .cpu_true_o(c_t), .cpu_comp_o(c_c), .se_o(se_in));
  cpdc_top #(.WAKE_CYCLES(WAKE)) dut (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i),
    .power_down_n_i(pd_n), .tristate_cfg_i(cfg), .cpu_clk_true_i(c_t),
    .cpu_clk_comp_i(c_c), .se_clk_i(se_in), .se_clk_o(se_out),
    .cpu_clk_true_out_o(t_out), .cpu_clk_true_oe_o(t_oe), .cpu_iref_2x_o(iref),
    .cpu_clk_comp_out_o(c_out), .cpu_clk_comp_oe_o(c_oe), .pll_enable_o(pll));
  initial
  begin
    forever #2 sys_clk_i = ~sys_clk_i;
  end
  function automatic int unsigned xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic logic exp_oe(input logic tri_c);
    return ~tri_c;
  endfunction
  function automatic logic probe(input int sel);
    case (sel)
      0: return pll;
      1: return c_oe;
      default: return |se_out;
    endcase
  endfunction
  task automatic print_verdict();
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic check_bit(input string what, input logic exp, input logic got);
    n_compared++;
    if (got !== exp)
    begin
      $display("unexpected %s expected %b seen %b", what, exp, got);
      bad_count++;
    end
  endtask
  task automatic check_vec(input string what, input logic [SE_NUM-1:0] exp,
                           input logic [SE_NUM-1:0] got);
    n_compared++;
    if (got !== exp)
    begin
      $display("unexpected %s expected %h seen %h", what, exp, got);
      bad_count++;
    end
  endtask
  task automatic wait_for(input string what, input int sel, input logic lvl, input int bound);
    int n;
    n = 0;
    while (probe(sel) !== lvl && n < bound)
    begin
      @(posedge sys_clk_i);
      #1;
      n++;
    end
    if (probe(sel) !== lvl)
    begin
      $display("unexpected %s expected %b seen %b", what, lvl, probe(sel));
      bad_count++;
      print_verdict();
    end
  endtask
  task automatic check_run(input int n);
    repeat (n)
    begin
      @(posedge sys_clk_i);
      #1;
      check_vec("se_clk_o", se_d2, se_out);
      check_bit("cpu_clk_true_out_o", c_d1, t_out);
      check_bit("cpu_clk_comp_out_o", ~c_d1, c_out);
      check_bit("cpu_clk_true_oe_o", 1'h1, t_oe);
      check_bit("cpu_clk_comp_oe_o", 1'h1, c_oe);
      check_bit("cpu_iref_2x_o", 1'h0, iref);
      check_bit("pll_enable_o", 1'h1, pll);
    end
  endtask
  // ==========================================================
  // Pulse length watch on the gated outputs
  // ==========================================================
  always @(posedge sys_clk_i)
  begin
    se_d1 <= se_in;
    se_d2 <= se_d1;
    c_d1 <= c_t;
    for (int k = 0; k < SE_NUM; k++)
    begin
      if (se_out[k] === 1'h1)
        hi_len[k] <= hi_len[k] + 1;
      else
      begin
        if (run_chk && hi_len[k] != 0)
          check_bit("se_clk_o pulse", 1'h1, hi_len[k] == 4);
        hi_len[k] <= 0;
      end
    end
  end
  // ==========================================================
  // Main sequence
  // ==========================================================
  initial
  begin
    phase <= SE_NUM'(xs());
    repeat (10) @(posedge sys_clk_i);
    rst_n_i <= 1'h1;
    repeat (20) @(posedge sys_clk_i);
    run_chk <= 1'h1;
    check_run(16);
    @(posedge sys_clk_i);
    pd_req <= 1'h1;
    repeat (4) @(posedge sys_clk_i);
    pd_req <= 1'h0;
    repeat (30) @(posedge sys_clk_i);
    check_run(16);
    $display("test single low sample done");
    for (int m = 0; m < 2; m++)
    begin
      @(posedge sys_clk_i);
      cfg <= m[0];
      pd_req <= 1'h1;
      wait_for("pll_enable_o", 0, 1'h0, 60);
      hold = 4 + xs() % 16;
      repeat (hold)
      begin
        @(posedge sys_clk_i);
        #1;
        check_vec("se_clk_o", {SE_NUM{1'h0}}, se_out);
        check_bit("cpu_clk_true_out_o", 1'h1, t_out);
        check_bit("cpu_clk_true_oe_o", exp_oe(cfg), t_oe);
        check_bit("cpu_iref_2x_o", exp_oe(cfg), iref);
        check_bit("cpu_clk_comp_oe_o", 1'h0, c_oe);
        check_bit("pll_enable_o", 1'h0, pll);
      end
      @(posedge sys_clk_i);
      pd_req <= 1'h0;
      wait_for("cpu_clk_comp_oe_o", 1, 1'h1, 10);
      check_bit("cpu_clk_true_out_o", 1'h0, t_out);
      check_bit("cpu_clk_comp_out_o", 1'h1, c_out);
      check_bit("cpu_clk_true_oe_o", 1'h1, t_oe);
      check_bit("pll_enable_o", 1'h1, pll);
      wait_for("se_clk_o", 2, 1'h1, WAKE + 16);
      repeat (4) @(posedge sys_clk_i);
      check_run(16);
      $display("test power-down cycle %0d done", m);
    end
    print_verdict();
  end
endmodule // testbench
